// ---- src/eik_pkg.sv ----
package eik_pkg;

  localparam int unsigned NUM_EXT = 4;
  localparam int unsigned NUM_SRC = 6;

  localparam logic [15:0] ADDR_EDGE_SEL_A = 16'hffec;
  localparam logic [15:0] ADDR_EDGE_SEL_B = 16'hffed;
  localparam logic [15:0] ADDR_KEY_WAKE_P6 = 16'hfff4;
  localparam logic [15:0] ADDR_KEY_WAKE_P0 = 16'hfff5;
  localparam logic [15:0] ADDR_REQ_FLAGS = 16'hffd0;
  localparam logic [15:0] ADDR_MASK_FLAGS = 16'hffd1;
  localparam logic [15:0] ADDR_PRIO_FLAGS = 16'hffd2;

  localparam logic [7:0] EDGE_SEL_A_RESET = 8'h00;
  localparam logic [7:0] EDGE_SEL_B_RESET = 8'h00;
  localparam logic [7:0] KEY_WAKE_RESET = 8'h00;
  localparam logic [7:0] PSW_RESET = 8'h02;
  localparam logic [5:0] REQ_RESET = 6'h00;
  localparam logic [5:0] MASK_RESET = 6'h3f;
  localparam logic [5:0] PRIO_RESET = 6'h3f;

  // Writable bits of the status word and the bits that always read one
  localparam logic [7:0] PSW_WR_MASK = 8'hd1;
  localparam logic [7:0] PSW_FORCED_ONES = 8'h02;
  localparam int unsigned PSW_IE_BIT = 7;

  localparam int unsigned EDGE_A_FIRST_BIT = 2;
  localparam int unsigned KEY_GROUP_BIT = 0;
  localparam int unsigned KEY_PIN_LO = 4;
  localparam int unsigned SRC_KEY_P0 = 4;
  localparam int unsigned SRC_KEY_P6 = 5;

  localparam logic [2:0] VEC_NMI = 3'h6;

  localparam int unsigned MIN_LATENCY_CLKS = 9;
  localparam int unsigned MAX_LATENCY_CLKS = 19;
  // Flag edge plus boundary edge precede the stacking sequence
  localparam int unsigned SEQ_CLKS = MIN_LATENCY_CLKS - 2;

  typedef enum logic [2:0] {
    EIK_IDLE = 3'b000,
    EIK_PUSH_PSW = 3'b001,
    EIK_PUSH_PCH = 3'b010,
    EIK_PUSH_PCL = 3'b011,
    EIK_SETTLE = 3'b100,
    EIK_BRANCH = 3'b101
  } eik_seq_e;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [15:0] addr;
    logic [7:0] wdata;
  } eik_mem_req_s;

  typedef struct packed {
    logic wr;
    logic bit_wr;
    logic [2:0] bit_idx;
    logic bit_val;
    logic [7:0] wdata;
  } eik_psw_req_s;

  typedef struct packed {
    logic we;
    logic [7:0] data;
  } eik_push_s;

endpackage

// ---- src/eik_edge_unit.sv ----
`timescale 1ns/1ns
module eik_edge_unit
  import eik_pkg::*;
#(
  parameter int unsigned WIDTH = 6
) (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic [WIDTH-1:0] level,
  input wire logic [WIDTH-1:0] rise_en,
  input wire logic [WIDTH-1:0] fall_en,
  output logic [WIDTH-1:0] pulse
);

  logic [WIDTH-1:0] prev_reg;
  logic armed_reg;

  // First cycle after reset only samples, so a pin high at reset is no edge
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      prev_reg <= '0;
      armed_reg <= 1'b0;
    end else begin
      prev_reg <= level;
      armed_reg <= 1'b1;
    end
  end

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      always_ff @(posedge clock) begin
        if (!reset_n) begin
          pulse[i] <= 1'b0;
        end else begin
          pulse[i] <= armed_reg &
            ((rise_en[i] & ~prev_reg[i] & level[i]) |
             (fall_en[i] & prev_reg[i] & ~level[i]));
        end
      end
    end
  endgenerate

endmodule // eik_edge_unit

// ---- src/eik_irq_ctrl.sv ----
`timescale 1ns/1ns
module eik_irq_ctrl
  import eik_pkg::*;
#(
  parameter int unsigned SETTLE_CLKS = SEQ_CLKS - 3
) (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic [NUM_EXT-1:0] external_irq_input,
  input wire logic [7:0] port0_key_pins,
  input wire logic [7:0] port6_key_pins,
  input wire logic nmi_request,
  input wire eik_mem_req_s mem_req,
  input wire eik_psw_req_s psw_req,
  input wire logic unmask_all_op,
  input wire logic mask_all_op,
  input wire logic return_from_handler_op,
  input wire logic [7:0] restored_psw,
  input wire logic instr_last_clk,
  input wire logic instr_touches_flags,
  input wire logic [15:0] pc_in,
  output logic [7:0] mem_rdata,
  output logic [7:0] program_status_word,
  output eik_push_s stack_push,
  output logic vector_load,
  output logic [2:0] vector_id,
  output logic service_busy,
  output logic nmi_in_service
);

  logic [7:0] edge_sel_a_reg;
  logic [7:0] edge_sel_b_reg;
  logic [7:0] key_wake_port0_enable;
  logic [7:0] key_wake_port6_enable;
  logic [5:0] req_reg;
  logic [5:0] mask_reg;
  logic [5:0] prio_reg;
  logic nmi_pend_reg;
  logic hold_reg;
  eik_seq_e state_reg;
  logic [7:0] settle_cnt_reg;
  logic [2:0] src_reg;
  logic [15:0] pc_reg;

  logic [NUM_EXT-1:0] ext_rise;
  logic [NUM_EXT-1:0] ext_fall;
  logic [1:0] ext_code [NUM_EXT];
  logic [7:0] p0_sel;
  logic [7:0] p6_sel;
  logic p0_level;
  logic p6_level;
  logic [NUM_SRC-1:0] edge_pulse;
  logic [NUM_SRC-1:0] eligible;
  logic [NUM_SRC-1:0] eligible_hi;
  logic at_boundary;
  logic accept_nmi;
  logic accept_mask;
  logic accept;
  logic [2:0] pick_src;
  logic flag_access;
  logic [5:0] ack_clear;

  // Returns {rise, fall} for a two-bit edge code
  function automatic logic [1:0] edge_decode(input logic [1:0] code);
    unique case (code)
      2'b00: edge_decode = 2'b01;
      2'b01: edge_decode = 2'b10;
      2'b11: edge_decode = 2'b11;
      default: edge_decode = 2'b00;
    endcase
  endfunction

  // Lowest index wins inside one priority level
  function automatic logic [2:0] first_set(input logic [NUM_SRC-1:0] v);
    first_set = 3'h0;
    for (int k = NUM_SRC - 1; k >= 0; k--) begin
      if (v[k]) begin
        first_set = 3'(k);
      end
    end
  endfunction

  // Forces the bits that never store a value
  function automatic logic [7:0] psw_fix(input logic [7:0] v);
    psw_fix = (v & PSW_WR_MASK) | PSW_FORCED_ONES;
  endfunction

  // Group enable fans out to pins 0-3, per-pin bits cover 4-7
  function automatic logic [7:0] key_select(input logic [7:0] en);
    key_select = {en[7:KEY_PIN_LO], {4{en[KEY_GROUP_BIT]}}};
  endfunction

  assign ext_code[0] = edge_sel_a_reg[EDGE_A_FIRST_BIT +: 2];
  assign ext_code[1] = edge_sel_a_reg[EDGE_A_FIRST_BIT + 2 +: 2];
  assign ext_code[2] = edge_sel_a_reg[EDGE_A_FIRST_BIT + 4 +: 2];
  assign ext_code[3] = edge_sel_b_reg[1:0];

  genvar g;
  generate
    for (g = 0; g < NUM_EXT; g++) begin : g_ext
      assign {ext_rise[g], ext_fall[g]} = edge_decode(ext_code[g]);
    end
  endgenerate

  assign p0_sel = key_select(key_wake_port0_enable);
  assign p6_sel = key_select(key_wake_port6_enable);
  // Wired-AND of enabled pins: one held low hides edges on the rest
  assign p0_level = &(port0_key_pins | ~p0_sel);
  assign p6_level = &(port6_key_pins | ~p6_sel);

  // Pad level is sampled whatever the pin direction, so output mode still detects
  eik_edge_unit #(
    .WIDTH(NUM_SRC)
  ) u_edges (
    .clock(clock),
    .reset_n(reset_n),
    .level({p6_level, p0_level, external_irq_input}),
    .rise_en({2'b00, ext_rise}),
    .fall_en({|p6_sel, |p0_sel, ext_fall}),
    .pulse(edge_pulse)
  );

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      edge_sel_a_reg <= EDGE_SEL_A_RESET;
      edge_sel_b_reg <= EDGE_SEL_B_RESET;
    end else if (mem_req.wr) begin
      if (mem_req.addr == ADDR_EDGE_SEL_A) begin
        edge_sel_a_reg <= mem_req.wdata;
      end
      if (mem_req.addr == ADDR_EDGE_SEL_B) begin
        edge_sel_b_reg <= mem_req.wdata;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      key_wake_port0_enable <= KEY_WAKE_RESET;
      key_wake_port6_enable <= KEY_WAKE_RESET;
    end else if (mem_req.wr) begin
      if (mem_req.addr == ADDR_KEY_WAKE_P0) begin
        key_wake_port0_enable <= mem_req.wdata;
      end
      if (mem_req.addr == ADDR_KEY_WAKE_P6) begin
        key_wake_port6_enable <= mem_req.wdata;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      mask_reg <= MASK_RESET;
      prio_reg <= PRIO_RESET;
    end else if (mem_req.wr) begin
      if (mem_req.addr == ADDR_MASK_FLAGS) begin
        mask_reg <= mem_req.wdata[5:0];
      end
      if (mem_req.addr == ADDR_PRIO_FLAGS) begin
        prio_reg <= mem_req.wdata[5:0];
      end
    end
  end

  // Accepted source loses its flag; a fresh edge in the same cycle still sets it
  always_comb begin
    ack_clear = '0;
    if (accept_mask) begin
      ack_clear[pick_src] = 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      req_reg <= REQ_RESET;
    end else if (mem_req.wr && mem_req.addr == ADDR_REQ_FLAGS) begin
      req_reg <= mem_req.wdata[5:0] | edge_pulse;
    end else begin
      req_reg <= (req_reg & ~ack_clear) | edge_pulse;
    end
  end

  // Non-maskable request is latched until taken; a new one wins over the take
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      nmi_pend_reg <= 1'b0;
    end else begin
      nmi_pend_reg <= nmi_request | (nmi_pend_reg & ~accept_nmi);
    end
  end

  assign flag_access = (mem_req.wr | mem_req.rd) &
    (mem_req.addr == ADDR_REQ_FLAGS || mem_req.addr == ADDR_MASK_FLAGS);

  // Remembers a flag access until the instruction that made it completes
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      hold_reg <= 1'b0;
    end else if (instr_last_clk) begin
      hold_reg <= 1'b0;
    end else if (flag_access) begin
      hold_reg <= 1'b1;
    end
  end

  // Flags are seen as registered, so a set in the final clock misses this boundary
  assign at_boundary = instr_last_clk & ~instr_touches_flags & ~hold_reg &
    ~flag_access & (state_reg == EIK_IDLE);

  assign eligible = req_reg & ~mask_reg & {NUM_SRC{program_status_word[PSW_IE_BIT]}};
  assign eligible_hi = eligible & ~prio_reg;
  assign pick_src = (|eligible_hi) ? first_set(eligible_hi) : first_set(eligible);

  assign accept_nmi = at_boundary & nmi_pend_reg;
  assign accept_mask = at_boundary & ~nmi_pend_reg & (|eligible);
  assign accept = accept_nmi | accept_mask;

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      program_status_word <= PSW_RESET;
    end else if (accept) begin
      program_status_word[PSW_IE_BIT] <= 1'b0;
    end else if (return_from_handler_op) begin
      program_status_word <= psw_fix(restored_psw);
    end else if (psw_req.wr) begin
      program_status_word <= psw_fix(psw_req.wdata);
    end else if (psw_req.bit_wr) begin
      program_status_word <= psw_fix(program_status_word &
        ~(8'h01 << psw_req.bit_idx) | ({7'h00, psw_req.bit_val} << psw_req.bit_idx));
    end else if (unmask_all_op) begin
      program_status_word[PSW_IE_BIT] <= 1'b1;
    end else if (mask_all_op) begin
      program_status_word[PSW_IE_BIT] <= 1'b0;
    end
  end

  // Fixed-length stacking keeps the fastest path at the minimum latency;
  // the maximum holds only while the core ends instructions within ten clocks
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      state_reg <= EIK_IDLE;
      settle_cnt_reg <= 8'h00;
    end else begin
      unique case (state_reg)
        EIK_IDLE: begin
          if (accept) begin
            state_reg <= EIK_PUSH_PSW;
          end
        end
        EIK_PUSH_PSW: begin
          state_reg <= EIK_PUSH_PCH;
        end
        EIK_PUSH_PCH: begin
          state_reg <= EIK_PUSH_PCL;
          settle_cnt_reg <= 8'(SETTLE_CLKS);
        end
        EIK_PUSH_PCL: begin
          state_reg <= EIK_SETTLE;
        end
        EIK_SETTLE: begin
          if (settle_cnt_reg <= 8'h01) begin
            state_reg <= EIK_BRANCH;
          end else begin
            settle_cnt_reg <= settle_cnt_reg - 8'h01;
          end
        end
        EIK_BRANCH: begin
          state_reg <= EIK_IDLE;
        end
        default: begin
          state_reg <= EIK_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      src_reg <= 3'h0;
      pc_reg <= 16'h0000;
    end else if (accept) begin
      src_reg <= accept_nmi ? VEC_NMI : pick_src;
      pc_reg <= pc_in;
    end
  end

  // Status word first, then the PC high and low bytes
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      stack_push <= '0;
    end else begin
      unique case (state_reg)
        EIK_IDLE: stack_push <= accept ? '{we: 1'b1, data: program_status_word} : '0;
        EIK_PUSH_PSW: stack_push <= '{we: 1'b1, data: pc_reg[15:8]};
        EIK_PUSH_PCH: stack_push <= '{we: 1'b1, data: pc_reg[7:0]};
        default: stack_push <= '0;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      vector_load <= 1'b0;
      vector_id <= 3'h0;
    end else begin
      vector_load <= (state_reg == EIK_SETTLE) && (settle_cnt_reg <= 8'h01);
      vector_id <= src_reg;
    end
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      service_busy <= 1'b0;
    end else begin
      service_busy <= accept || (state_reg != EIK_IDLE && state_reg != EIK_BRANCH);
    end
  end

  // Left set until return; a second one may still interrupt its own handler
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      nmi_in_service <= 1'b0;
    end else if (accept_nmi) begin
      nmi_in_service <= 1'b1;
    end else if (return_from_handler_op) begin
      nmi_in_service <= 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      mem_rdata <= 8'h00;
    end else if (mem_req.rd) begin
      unique case (mem_req.addr)
        ADDR_EDGE_SEL_A: mem_rdata <= edge_sel_a_reg;
        ADDR_EDGE_SEL_B: mem_rdata <= edge_sel_b_reg;
        ADDR_KEY_WAKE_P0: mem_rdata <= key_wake_port0_enable;
        ADDR_KEY_WAKE_P6: mem_rdata <= key_wake_port6_enable;
        ADDR_REQ_FLAGS: mem_rdata <= {2'b00, req_reg};
        ADDR_MASK_FLAGS: mem_rdata <= {2'b11, mask_reg};
        ADDR_PRIO_FLAGS: mem_rdata <= {2'b11, prio_reg};
        default: mem_rdata <= 8'h00;
      endcase
    end
  end

endmodule // eik_irq_ctrl

// ---- verif/eik_irq_monitor.sv ----
`timescale 1ns/1ns
module eik_irq_monitor
  import eik_pkg::*;
#(
  parameter int unsigned SETTLE_CLKS = SEQ_CLKS - 3
) (
  input wire logic clock,
  input wire logic reset_n,
  input wire eik_psw_req_s psw_req,
  input wire logic unmask_all_op,
  input wire logic return_from_handler_op,
  input wire logic instr_last_clk,
  input wire logic instr_touches_flags,
  input wire logic [15:0] pc_in,
  input wire logic [7:0] program_status_word,
  input wire eik_push_s stack_push,
  input wire logic vector_load,
  input wire logic [2:0] vector_id,
  input wire logic service_busy,
  input wire logic nmi_in_service
);
  // Vector follows the three pushes and the settle time
  localparam int VL_DLY = SETTLE_CLKS + 3;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);
  sequence seq_push3;
    stack_push.we [*3] ##1 !stack_push.we;
  endsequence
  // Return address bytes were captured at the acceptance edge
  sequence seq_push_pc;
    ##1 stack_push.data == $past(pc_in[15:8], 2) ##1 stack_push.data == $past(pc_in[7:0], 3);
  endsequence
  sequence seq_vector;
    ##VL_DLY vector_load ##1 !service_busy;
  endsequence
  AST_PSW_FIXED:
    assert property ((program_status_word & 8'h2e) == 8'h02)
    else $error("status word fixed bits wrong");
  AST_PUSH_SEQ:
    assert property ($rose(service_busy) |-> seq_push3)
    else $error("stack pushes not three in a row");
  AST_PUSH_PSW:
    assert property ($rose(service_busy) |-> stack_push.data == $past(program_status_word))
    else $error("first push is not the status word");
  AST_PUSH_PC:
    assert property ($rose(service_busy) |-> seq_push_pc)
    else $error("saved return address wrong");
  AST_HOLD_TOUCH:
    assert property (instr_touches_flags |=> !$rose(service_busy))
    else $error("request taken during flag access");
  AST_IE_CLEARED:
    assert property ($rose(service_busy) |-> !program_status_word[PSW_IE_BIT])
    else $error("global enable not cleared on acceptance");
  AST_VECTOR_AFTER:
    assert property ($rose(service_busy) |-> seq_vector)
    else $error("vector load late or early");
  AST_ONE_VECTOR:
    assert property (vector_load |=> !vector_load)
    else $error("vector load longer than one cycle");
  AST_NMI_VECTOR:
    assert property ($rose(nmi_in_service) |-> ##[0:10] (vector_load && vector_id == VEC_NMI))
    else $error("non-maskable vector missing");
  AST_IE_BYTE:
    assert property (psw_req.wr && !instr_last_clk && !return_from_handler_op
      |=> program_status_word[7] == $past(psw_req.wdata[7]))
    else $error("byte write did not set global enable");
  AST_IE_ENABLE:
    assert property (unmask_all_op && !psw_req.wr && !psw_req.bit_wr && !return_from_handler_op
      && !instr_last_clk |=> program_status_word[7])
    else $error("enable op did not set global enable");
endmodule // eik_irq_monitor

// ---- verif/eik_pin_model.sv ----
`timescale 1ns/1ns
module eik_pin_model (
  input wire logic clock,
  input wire logic [3:0] ext_lvl,
  input wire logic [7:0] p0_lvl,
  input wire logic [7:0] p6_lvl,
  output logic [3:0] ext_pins,
  output logic [7:0] p0_pins,
  output logic [7:0] p6_pins
);
  // Lines follow the commanded level one edge later, like a slow pad
  always_ff @(posedge clock) begin
    ext_pins <= ext_lvl;
    p0_pins <= p0_lvl;
    p6_pins <= p6_lvl;
  end
endmodule // eik_pin_model

// ---- verif/testbench.sv ----
`timescale 1ns/1ns
module testbench;
  import eik_pkg::*;
  logic clock = 0;
  logic reset_n = 0;
  logic [3:0] ext_lvl = 4'h0;
  logic [7:0] p0_lvl = 8'hff;
  logic [7:0] p6_lvl = 8'hff;
  logic [3:0] ext_pins;
  logic [7:0] p0_pins;
  logic [7:0] p6_pins;
  logic nmi_request = 0;
  logic unmask_all_op = 0;
  logic mask_all_op = 0;
  logic return_from_handler_op = 0;
  logic instr_last_clk = 0;
  logic instr_touches_flags = 0;
  bit lat_on = 1'b1;
  logic [7:0] restored_psw = 8'h82;
  logic [15:0] pc_in = 16'h0000;
  eik_mem_req_s mem_req = '0;
  eik_psw_req_s psw_req = '0;
  logic [7:0] mem_rdata;
  logic [7:0] program_status_word;
  eik_push_s stack_push;
  logic vector_load;
  logic service_busy;
  logic nmi_in_service;
  logic [2:0] vector_id;
  int mismatches = 0;
  int checks_done = 0;
  int cyc = 0;
  int pin_cyc = 0;
  int lat;
  int n;
  int c;
  int exp_q[$];
  integer seed = 32'hbaa3a777;
  logic [7:0] d;
  logic [15:0] ra[4] = '{16'hffec, 16'hffed, 16'hfff4, 16'hfff5};
  logic [7:0] rm[4] = '{8'hfc, 8'h03, 8'hf1, 8'hf1};

  always #5 clock = ~clock;
  // Core model: four-clock instructions, random return address
  always @(posedge clock) begin
    cyc <= cyc + 1;
    instr_last_clk <= #1 (cyc % 4 == 3);
    pc_in <= #1 16'($random(seed));
  end

  eik_pin_model eik_pin_model_inst (.clock, .ext_lvl, .p0_lvl, .p6_lvl, .ext_pins, .p0_pins,
    .p6_pins);
  eik_irq_ctrl eik_irq_ctrl_inst (.clock, .reset_n, .external_irq_input(ext_pins),
    .port0_key_pins(p0_pins), .port6_key_pins(p6_pins), .nmi_request, .mem_req, .psw_req,
    .unmask_all_op, .mask_all_op, .return_from_handler_op, .restored_psw, .instr_last_clk,
    .instr_touches_flags, .pc_in, .mem_rdata, .program_status_word, .stack_push,
    .vector_load, .vector_id, .service_busy, .nmi_in_service);

  task automatic tick(input int k = 1);
    repeat (k) @(posedge clock);
    #1;
  endtask
  task automatic cmp(input logic [7:0] g, input logic [7:0] e);
    checks_done++;
    if (g !== e) begin
      mismatches++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] v);
    mem_req = '{1'b1, 1'b0, a, v};
    tick();
    mem_req = '0;
    tick();
  endtask
  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    mem_req = '{1'b0, 1'b1, a, 8'h00};
    tick();
    mem_req = '0;
    cmp(mem_rdata, e);
    tick();
  endtask
  task automatic pulse(ref logic s);
    s = 1'b1;
    tick();
    s = 1'b0;
    tick();
  endtask
  task automatic settle();
    pin_cyc = cyc;
    tick(40);
  endtask
  task automatic psw_wr(input logic [7:0] v, input logic [7:0] e);
    psw_req = '{1'b1, 1'b0, 3'd0, 1'b0, v};
    tick();
    psw_req = '0;
    tick();
    cmp(program_status_word, e);
  endtask
  task automatic psw_bit(input logic [2:0] i, input logic v, input logic [7:0] e);
    psw_req = '{1'b0, 1'b1, i, v, 8'h00};
    tick();
    psw_req = '0;
    tick();
    cmp(program_status_word, e);
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // Handler model: check each vector against the queue, then return with IE set
  initial forever begin
    @(negedge clock iff vector_load === 1'b1);
    cmp({5'h00, vector_id}, (exp_q.size() > 0) ? 8'(exp_q.pop_front()) : 8'hff);
    lat = cyc - pin_cyc - 1;
    // Latency only counts when nothing else delays the request
    if (vector_id !== VEC_NMI && lat_on)
      cmp(8'(lat >= 9 && lat <= 19), 8'h01);
    repeat (3) @(posedge clock);
    #1 return_from_handler_op = 1'b1;
    @(posedge clock);
    #1 return_from_handler_op = 1'b0;
  end

  initial begin
    tick(20000);
    mismatches++;
    finish_test();
  end

  initial begin
    tick(2);
    reset_n = 1'b1;
    cmp(program_status_word, 8'h02);
    for (n = 0; n < 4; n++)
      rd(ra[n], 8'h00);
    rd(16'hff00, 8'h00);
    for (n = 0; n < 4; n++) begin
      d = 8'($random(seed)) & rm[n];
      wr(ra[n], d);
      rd(ra[n], d);
    end
    pulse(unmask_all_op);
    cmp(program_status_word, 8'h82);
    psw_wr(8'hff, 8'hd3);
    psw_wr(8'h80, 8'h82);
    psw_bit(3'd7, 1'b0, 8'h02);
    psw_bit(3'd2, 1'b1, 8'h02);
    psw_bit(3'd7, 1'b1, 8'h82);
    for (n = 0; n < 4; n++) begin
      for (c = 0; c < 4; c++) begin
        wr(16'hffd1, 8'h3f);
        if (n < 3)
          wr(16'hffec, 8'(c << (2 * n + 2)));
        else
          wr(16'hffed, 8'(c));
        wr(16'hffd0, 8'h00);
        wr(16'hffd1, 8'h3f & ~(8'h01 << n));
        if (c == 1 || c == 3)
          exp_q.push_back(n);
        ext_lvl[n] = 1'b1;
        settle();
        if (c == 0 || c == 3)
          exp_q.push_back(n);
        ext_lvl[n] = 1'b0;
        settle();
        cmp(8'(exp_q.size()), 8'h00);
      end
    end
    wr(16'hffd1, 8'h3f);
    wr(16'hffec, 8'h14);
    wr(16'hffd2, 8'h3d);
    wr(16'hffd0, 8'h00);
    wr(16'hffd1, 8'h3c);
    exp_q.push_back(1);
    exp_q.push_back(0);
    lat_on = 1'b0;
    ext_lvl[1:0] = 2'b11;
    settle();
    cmp(8'(exp_q.size()), 8'h00);
    ext_lvl[0] = 1'b0;
    instr_touches_flags = 1'b1;
    tick(4);
    ext_lvl[0] = 1'b1;
    settle();
    cmp(8'(exp_q.size()), 8'h00);
    exp_q.push_back(0);
    instr_touches_flags = 1'b0;
    settle();
    cmp(8'(exp_q.size()), 8'h00);
    lat_on = 1'b1;
    ext_lvl = 4'h0;
    wr(16'hffd1, 8'h3f);
    wr(16'hfff5, 8'h11);
    wr(16'hffd0, 8'h00);
    wr(16'hffd1, 8'h2f);
    exp_q.push_back(4);
    p0_lvl[2] = 1'b0;
    settle();
    p0_lvl[4] = 1'b0;
    settle();
    p0_lvl = 8'hff;
    settle();
    cmp(8'(exp_q.size()), 8'h00);
    wr(16'hffd1, 8'h3f);
    wr(16'hfff4, 8'h10);
    wr(16'hffd0, 8'h00);
    wr(16'hffd1, 8'h1f);
    exp_q.push_back(5);
    p6_lvl[4] = 1'b0;
    settle();
    p6_lvl[0] = 1'b0;
    settle();
    cmp(8'(exp_q.size()), 8'h00);
    wr(16'hffd1, 8'h3f);
    wr(16'hfff4, 8'h00);
    rd(16'hfff4, 8'h00);
    pulse(mask_all_op);
    cmp(program_status_word, 8'h02);
    exp_q.push_back(6);
    pulse(nmi_request);
    settle();
    cmp(8'(exp_q.size()), 8'h00);
    finish_test();
  end
endmodule // testbench

bind eik_irq_ctrl eik_irq_monitor #(.SETTLE_CLKS(SETTLE_CLKS)) eik_irq_monitor_inst (.clock,
  .reset_n, .psw_req, .unmask_all_op, .return_from_handler_op, .instr_last_clk,
  .instr_touches_flags, .pc_in,
  .program_status_word, .stack_push, .vector_load, .vector_id, .service_busy, .nmi_in_service);
